/* File: cgr_pkg.sv */
/*
  Shared constants for the clock generator reset and adjust control: register map,
  reset values, timing counts and the soft-reset sequencer states.
  Assumes a 50 MHz system clock on both ends of the link.
*/
package cgr_pkg;
  // Number of output clocks controlled by the block.
  localparam int NUM_OUT = 4;
  // System clock rate in kHz.
  localparam int CLK_KHZ = 50000;
  // PLL lock wait in ms and in cycles.
  localparam int LOCK_WAIT_MS = 25;
  localparam int LOCK_WAIT_CYC = LOCK_WAIT_MS * CLK_KHZ;
  // Length of the calibration and synthesizer initialisation step in cycles.
  localparam int CAL_CYC = 16;
  // Fastest step pin rate in kHz and the shortest pin period in cycles, rounded up.
  localparam int PIN_RATE_KHZ = 1500;
  localparam int PIN_PERIOD_CYC = (CLK_KHZ + PIN_RATE_KHZ - 1) / PIN_RATE_KHZ;
  localparam int PIN_HIGH_CYC = PIN_PERIOD_CYC / 2;
  // Phase range and step, and the resulting step limit each way.
  localparam int PHASE_RANGE_PS = 45000;
  localparam int PHASE_STEP_PS = 20;
  localparam int PHASE_LIMIT = PHASE_RANGE_PS / PHASE_STEP_PS;
  // Device register offsets; the per-output groups add the output number.
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_FSTEP = 8'h20;
  localparam logic [7:0] OFS_FCMD = 8'h24;
  localparam logic [7:0] OFS_PSTEP = 8'h30;
  localparam logic [7:0] OFS_PCMD = 8'h34;
  localparam logic [7:0] OFS_PINIT = 8'h38;
  localparam logic [7:0] OFS_SSAMT = 8'h40;
  localparam logic [7:0] OFS_SSMODE = 8'h44;
  localparam logic [7:0] OFS_SSRATE = 8'h48;
  localparam logic [7:0] OFS_MISC = 8'h50;
  localparam logic [7:0] OFS_OEN = 8'h51;
  localparam logic [7:0] OFS_STAT = 8'h60;
  localparam logic [7:0] OFS_SRST = 8'hF6;
  // Value that starts a soft reset.
  localparam logic [7:0] SRST_CMD = 8'h02;
  // Configuration field positions.
  localparam int CFG_ALWAYS_ON = 3;
  localparam int CFG_INVERT = 4;
  localparam int CFG_SYNC = 5;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  // Spread limits in 0.1 percent units, rate limits in 0.5 kHz units.
  localparam logic [7:0] SS_AMT_MIN = 8'h01;
  localparam logic [7:0] SS_CENTER_MAX = 8'h19;
  localparam logic [7:0] SS_DOWN_MAX = 8'h32;
  localparam logic [7:0] SS_RATE_MIN = 8'h3C;
  localparam logic [7:0] SS_RATE_MAX = 8'h7E;
  // Reset values: 31.5 kHz rate, 0.5 percent down spread, spread off.
  localparam logic [7:0] SS_RATE_RST = 8'h3F;
  localparam logic [7:0] SS_AMT_RST = 8'h05;
  localparam logic [7:0] SS_MODE_RST = 8'h02;
  localparam logic [7:0] OEN_RST = 8'h0F;
  // Controller APB offsets.
  localparam logic [11:0] APB_XFER = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam logic [11:0] APB_PIN = 12'h008;
  // Soft-reset sequencer states.
  typedef enum logic [4:0] {
    CGR_IDLE = 5'b00001,
    CGR_OFF = 5'b00010,
    CGR_CAL = 5'b00100,
    CGR_LOCK = 5'b01000,
    CGR_ON = 5'b10000
  } cgr_seq_t;
endpackage : cgr_pkg

/* File: cgr_link_if.sv */
/*
  Link between the controller and the clock generator control logic: a byte
  register port and four step pins. Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
interface cgr_link_if;
  // Register port.
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  // Step pins: frequency up, frequency down, phase up, phase down.
  logic [3:0] step_pins;
  modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, input step_pins,
    output reg_rdata, output reg_rvalid);
  modport ctl (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, output step_pins,
    input reg_rdata, input reg_rvalid);
endinterface : cgr_link_if

/* File: cgr_dev.sv */
/*
  Device end: soft-reset sequencer, per-output frequency and phase step control,
  output enables and spread parameters behind a byte register port.
  Assumes step pins are asynchronous and the register port is on pclk.
*/
// Implementation choice: register access over a byte register port.
`timescale 1ns/1ps
module cgr_dev #(
  parameter int LOCK_CYC = cgr_pkg::LOCK_WAIT_CYC
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Link to the controller.
  cgr_link_if.dev link,
  // Output clock control toward the analog side.
  output logic [cgr_pkg::NUM_OUT-1:0] out_run,
  output logic [cgr_pkg::NUM_OUT-1:0] out_align,
  output logic [cgr_pkg::NUM_OUT-1:0] out_align_rise,
  output logic synth_init,
  output logic [cgr_pkg::NUM_OUT*3-1:0] out_div_code,
  output logic [cgr_pkg::NUM_OUT*16-1:0] freq_ofs_ppm,
  output logic [cgr_pkg::NUM_OUT*13-1:0] phase_ofs,
  output logic [cgr_pkg::NUM_OUT*8-1:0] ss_amount,
  output logic [cgr_pkg::NUM_OUT-1:0] ss_enable,
  output logic [cgr_pkg::NUM_OUT-1:0] ss_down,
  output logic [7:0] ss_rate,
  output logic seq_busy
);
  import cgr_pkg::*;

  // Soft-reset state, step counter and the mask of outputs it turned off.
  cgr_seq_t state_reg;
  logic [31:0] cnt_reg;
  logic [NUM_OUT-1:0] off_mask_reg;
  // Global registers.
  logic [7:0] srst_reg;
  logic [7:0] misc_reg;
  logic [7:0] oen_reg;
  logic [7:0] ssrate_reg;
  // Pin synchroniser stages and rising-edge pulses.
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_rise;
  // Per-output configuration gathered for readback.
  wire [NUM_OUT*8-1:0] cfg_bus;
  wire [NUM_OUT-1:0] always_on;
  // Write strobes for the commands, and the calibration-entry flag.
  logic srst_hit;
  logic fcmd_wr;
  logic pcmd_wr;
  logic cal_entry;

  assign srst_hit = link.reg_wr && link.reg_addr == OFS_SRST && link.reg_wdata == SRST_CMD;
  assign fcmd_wr = link.reg_wr && link.reg_addr == OFS_FCMD;
  assign pcmd_wr = link.reg_wr && link.reg_addr == OFS_PCMD;
  assign cal_entry = state_reg == CGR_OFF;
  assign seq_busy = state_reg != CGR_IDLE;

  // Two flops before anything looks at the pins, a third only for edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end
    else if (ce)
    begin
      pin_s1 <= link.step_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  // One pulse per rising pin edge; a 34-cycle period leaves room for every edge.
  assign pin_rise = pin_s2 & ~pin_s3;

  // Global registers; the soft-reset byte keeps what was written.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srst_reg <= 8'h00;
      misc_reg <= 8'h00;
      oen_reg <= OEN_RST;
      ssrate_reg <= SS_RATE_RST;
    end
    else if (ce && link.reg_wr)
    begin
      case (link.reg_addr)
        OFS_SRST: srst_reg <= link.reg_wdata;
        OFS_MISC: misc_reg <= link.reg_wdata;
        OFS_OEN: oen_reg <= {4'h0, link.reg_wdata[3:0]};
        // Out-of-range rates are pulled to the nearest limit.
        OFS_SSRATE: ssrate_reg <= (link.reg_wdata < SS_RATE_MIN) ? SS_RATE_MIN :
          (link.reg_wdata > SS_RATE_MAX) ? SS_RATE_MAX : link.reg_wdata;
        default: ;
      endcase
    end
  end
  assign ss_rate = ssrate_reg;

  // Soft-reset sequencer; it never writes any configuration register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= CGR_IDLE;
      cnt_reg <= 32'h0;
      off_mask_reg <= '0;
      synth_init <= 1'b0;
    end
    else if (ce)
    begin
      synth_init <= cal_entry;
      case (state_reg)
        CGR_IDLE:
        begin
          // Requests are only taken here, so a running sequence finishes first.
          if (srst_hit)
          begin
            state_reg <= CGR_OFF;
          end
        end
        CGR_OFF:
        begin
          off_mask_reg <= oen_reg[NUM_OUT-1:0] & ~always_on;
          cnt_reg <= 32'h0;
          state_reg <= CGR_CAL;
        end
        CGR_CAL:
        begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(CAL_CYC - 1))
          begin
            cnt_reg <= 32'h0;
            state_reg <= misc_reg[0] ? CGR_ON : CGR_LOCK;
          end
        end
        CGR_LOCK:
        begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(LOCK_CYC - 1))
          begin
            cnt_reg <= 32'h0;
            state_reg <= CGR_ON;
          end
        end
        CGR_ON:
        begin
          off_mask_reg <= '0;
          state_reg <= CGR_IDLE;
        end
        default: state_reg <= CGR_IDLE;
      endcase
    end
  end

  // Per-output registers, accumulators and output controls.
  genvar n;
  generate
    for (n = 0; n < NUM_OUT; n++)
    begin : ch
      logic [7:0] cfg_reg;
      logic [7:0] fstep_reg;
      logic [7:0] pstep_reg;
      logic [7:0] pinit_reg;
      logic [7:0] ssamt_reg;
      logic [7:0] ssmode_reg;
      logic signed [15:0] facc_reg;
      logic signed [12:0] pacc_reg;
      logic f_up;
      logic f_dn;
      logic p_up;
      logic p_dn;
      logic unity;
      logic signed [13:0] p_next;
      logic [7:0] amt_max;
      // Only output zero listens to the pins.
      assign f_up = (fcmd_wr && link.reg_wdata[n]) || (n == 0 && pin_rise[0]);
      assign f_dn = (fcmd_wr && link.reg_wdata[n+4]) || (n == 0 && pin_rise[1]);
      assign p_up = (pcmd_wr && link.reg_wdata[n]) || (n == 0 && pin_rise[2]);
      assign p_dn = (pcmd_wr && link.reg_wdata[n+4]) || (n == 0 && pin_rise[3]);
      assign unity = cfg_reg[2:0] == 3'h0;
      assign amt_max = ssmode_reg[1] ? SS_DOWN_MAX : SS_CENTER_MAX;

      // Configuration writes; divider codes above 5 are held at 5.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cfg_reg <= 8'h00;
          fstep_reg <= 8'h01;
          pstep_reg <= 8'h01;
          pinit_reg <= 8'h00;
          ssamt_reg <= SS_AMT_RST;
          ssmode_reg <= SS_MODE_RST;
        end
        else if (ce && link.reg_wr)
        begin
          if (link.reg_addr == OFS_CFG + 8'(n))
          begin
            cfg_reg <= link.reg_wdata;
            if (link.reg_wdata[2:0] > DIV_MAX_CODE)
            begin
              cfg_reg[2:0] <= DIV_MAX_CODE;
            end
          end
          // A zero step size would stall stepping, so it becomes 1 ppm.
          if (link.reg_addr == OFS_FSTEP + 8'(n))
          begin
            fstep_reg <= (link.reg_wdata == 8'h00) ? 8'h01 : link.reg_wdata;
          end
          if (link.reg_addr == OFS_PSTEP + 8'(n))
          begin
            pstep_reg <= link.reg_wdata;
          end
          if (link.reg_addr == OFS_PINIT + 8'(n))
          begin
            pinit_reg <= link.reg_wdata;
          end
          if (link.reg_addr == OFS_SSAMT + 8'(n))
          begin
            ssamt_reg <= (link.reg_wdata < SS_AMT_MIN) ? SS_AMT_MIN :
              (link.reg_wdata > amt_max) ? amt_max : link.reg_wdata;
          end
          if (link.reg_addr == OFS_SSMODE + 8'(n))
          begin
            ssmode_reg <= {6'h0, link.reg_wdata[1:0]};
          end
        end
      end

      // Frequency offset in ppm; the synthesizer slews to it without a glitch.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          facc_reg <= 16'sh0;
        end
        else if (ce)
        begin
          if (f_up && !f_dn)
          begin
            facc_reg <= facc_reg + signed'({8'h0, fstep_reg});
          end
          else if (f_dn && !f_up)
          begin
            facc_reg <= facc_reg - signed'({8'h0, fstep_reg});
          end
        end
      end

      // Phase offset in 20 ps units, clamped at the range ends; 12 bits cannot hold 2250, so it takes 13.
      assign p_next = p_up ? 14'(pacc_reg) + 14'(signed'({5'h0, pstep_reg})) :
        14'(pacc_reg) - 14'(signed'({5'h0, pstep_reg}));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pacc_reg <= 13'sh0;
        end
        else if (ce)
        begin
          if (cal_entry)
          begin
            // The programmed start offset holds only for undivided outputs.
            pacc_reg <= unity ? 13'(signed'(pinit_reg)) : 13'sh0;
          end
          else if (p_up != p_dn)
          begin
            pacc_reg <= (p_next > 14'(PHASE_LIMIT)) ? 13'(PHASE_LIMIT) :
              (p_next < -14'(PHASE_LIMIT)) ? -13'(PHASE_LIMIT) : p_next[12:0];
          end
        end
      end

      // Registered controls toward the outputs.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          out_run[n] <= 1'b0;
          out_align[n] <= 1'b0;
          out_align_rise[n] <= 1'b0;
        end
        else if (ce)
        begin
          out_run[n] <= cfg_reg[CFG_ALWAYS_ON] || (oen_reg[n] && !off_mask_reg[n]);
          out_align[n] <= cal_entry && cfg_reg[CFG_SYNC] && unity;
          out_align_rise[n] <= cfg_reg[CFG_INVERT];
        end
      end

      assign cfg_bus[n*8 +: 8] = cfg_reg;
      assign always_on[n] = cfg_reg[CFG_ALWAYS_ON];
      // The ppm step is kept at the synthesizer; the divider scales it at the pin.
      assign out_div_code[n*3 +: 3] = cfg_reg[2:0];
      assign freq_ofs_ppm[n*16 +: 16] = facc_reg;
      assign phase_ofs[n*13 +: 13] = pacc_reg;
      assign ss_amount[n*8 +: 8] = ssamt_reg;
      assign ss_enable[n] = ssmode_reg[0];
      assign ss_down[n] = ssmode_reg[1];
    end
  endgenerate

  // Read port: data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.reg_rdata <= 8'h00;
      link.reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      link.reg_rvalid <= link.reg_rd;
      if (link.reg_rd)
      begin
        case (link.reg_addr)
          OFS_SRST: link.reg_rdata <= srst_reg;
          OFS_MISC: link.reg_rdata <= misc_reg;
          OFS_OEN: link.reg_rdata <= oen_reg;
          OFS_SSRATE: link.reg_rdata <= ssrate_reg;
          OFS_STAT: link.reg_rdata <= {3'h0, seq_busy, out_run};
          default:
            link.reg_rdata <= (link.reg_addr[7:2] == OFS_CFG[7:2]) ? cfg_bus[link.reg_addr[1:0]*8 +: 8] : 8'h00;
        endcase
      end
    end
  end
endmodule : cgr_dev

/* File: cgr_ctl.sv */
/*
  Controller end: an APB slave whose registers issue byte transfers on the
  register port and timed pulses on the step pins. Assumes the device on pclk.
*/
`timescale 1ns/1ps
module cgr_ctl (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device.
  cgr_link_if.ctl link
);
  import cgr_pkg::*;

  // Transfer state: busy flag, pending read flag and the last read byte.
  logic xfer_busy_reg;
  logic xfer_rd_reg;
  logic [7:0] last_rdata_reg;
  // Pin pulse generator: active pin pattern and period counter.
  logic [3:0] pin_reg;
  logic [7:0] pin_cnt_reg;
  logic pin_busy_reg;
  // Access strobes.
  logic apb_wr;
  logic xfer_go;
  logic pin_go;
  logic bad_addr;

  assign apb_wr = psel && penable && pwrite;
  assign xfer_go = apb_wr && paddr == APB_XFER && !xfer_busy_reg;
  assign pin_go = apb_wr && paddr == APB_PIN && !pin_busy_reg && pwdata[3:0] != 4'h0;
  assign bad_addr = paddr != APB_XFER && paddr != APB_STAT && paddr != APB_PIN;
  assign pready = 1'b1;
  // Unmapped offsets and commands given while busy answer with an error.
  assign pslverr = psel && penable && (bad_addr || (pwrite && paddr == APB_XFER && xfer_busy_reg) ||
    (pwrite && paddr == APB_PIN && pin_busy_reg));
  always_comb
  begin
    case (paddr)
      APB_STAT: prdata = {16'h0, last_rdata_reg, 6'h0, pin_busy_reg, xfer_busy_reg};
      default: prdata = 32'h0;
    endcase
  end

  // Register transfers: one-cycle strobe, then wait for read data if reading.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.reg_addr <= 8'h00;
      link.reg_wdata <= 8'h00;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      xfer_busy_reg <= 1'b0;
      xfer_rd_reg <= 1'b0;
      last_rdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      if (xfer_go)
      begin
        // A soft reset is just a write of its command byte to its offset.
        link.reg_addr <= pwdata[7:0];
        link.reg_wdata <= pwdata[15:8];
        link.reg_wr <= !pwdata[16];
        link.reg_rd <= pwdata[16];
        xfer_rd_reg <= pwdata[16];
        xfer_busy_reg <= 1'b1;
      end
      else if (xfer_busy_reg && (!xfer_rd_reg || link.reg_rvalid))
      begin
        if (xfer_rd_reg)
        begin
          last_rdata_reg <= link.reg_rdata;
        end
        xfer_busy_reg <= 1'b0;
      end
    end
  end

  // Pin pulses: high for half a period, one period long at the fastest rate.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_reg <= 4'h0;
      pin_cnt_reg <= 8'h00;
      pin_busy_reg <= 1'b0;
      link.step_pins <= 4'h0;
    end
    else if (ce)
    begin
      if (pin_go)
      begin
        pin_reg <= pwdata[3:0];
        pin_cnt_reg <= 8'h00;
        pin_busy_reg <= 1'b1;
        link.step_pins <= pwdata[3:0];
      end
      else if (pin_busy_reg)
      begin
        pin_cnt_reg <= pin_cnt_reg + 8'h01;
        if (pin_cnt_reg == 8'(PIN_HIGH_CYC - 1))
        begin
          link.step_pins <= 4'h0;
        end
        if (pin_cnt_reg == 8'(PIN_PERIOD_CYC - 1))
        begin
          pin_busy_reg <= 1'b0;
          pin_reg <= 4'h0;
        end
      end
    end
  end
endmodule : cgr_ctl

/* File: cgr_assertions.sv */
/*
  Checker for the link between controller and device: register port strobes,
  soft-reset sequence length, output restore and step pin timing.
  Assumes one pclk domain and the device built with a short LOCK_CYC.
*/
`timescale 1ns/1ps
module cgr_assertions #(
  parameter int LOCK_CYC = 20
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register port and step pins.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] step_pins,
  // Device status.
  input wire logic [cgr_pkg::NUM_OUT-1:0] out_run,
  input wire logic seq_busy
);
  import cgr_pkg::*;
  int busy_cnt; // Cycles spent in the current sequence.
  logic [5:0] pin_gap; // Cycles since the last pin rise, saturating.
  logic [3:0] pins_q; // Pins one cycle ago.
  logic [3:0] run_before; // Running outputs when the sequence began.
  logic pin_rise;
  assign pin_rise = |(step_pins & ~pins_q);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the sequence, counted so both lock paths can be told apart.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_cnt <= 0;
    else
      busy_cnt <= seq_busy ? busy_cnt + 1 : 0;
  end
  // Pin spacing; starts saturated so the first pulse is always legal.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_q <= 4'h0;
      pin_gap <= 6'h3F;
    end
    else
    begin
      pins_q <= step_pins;
      pin_gap <= pin_rise ? 6'h00 : (pin_gap == 6'h3F ? pin_gap : pin_gap + 6'h01);
    end
  end
  // Snapshot of outputs at sequence start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_before <= 4'h0;
    else if (seq_busy && busy_cnt == 0)
      run_before <= out_run;
  end
  srst_start_a: assert property (reg_wr && reg_addr == OFS_SRST && reg_wdata == SRST_CMD && !seq_busy |=> seq_busy)
    else $error("soft reset write did not start the sequence");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("register write strobe longer than one cycle");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer missing or too long");
  seq_len_a: assert property ($fell(seq_busy) |-> (busy_cnt == 18 || busy_cnt == LOCK_CYC + 18))
    else $error("soft reset sequence has the wrong length");
  run_back_a: assert property ($fell(seq_busy) |=> out_run == run_before)
    else $error("outputs not restored after the sequence");
  seq_idle_a: assert property (!seq_busy && !(reg_wr && reg_addr == OFS_SRST) |=> !seq_busy)
    else $error("sequencer left idle without a request");
  pin_high_a: assert property ($rose(step_pins[0]) |-> step_pins[0] [*8])
    else $error("step pin pulse too short");
  pin_rate_a: assert property (pin_rise |-> pin_gap >= 6'h21)
    else $error("step pin pulses too close together");
  cover property ($fell(seq_busy));
  cover property (reg_rvalid);
  cover property (pin_rise);
endmodule : cgr_assertions

/* File: tb_top.sv */
/*
  Testbench: APB traffic into the controller, which drives the device across
  the link. Assumes a 50 MHz pclk and LOCK_CYC shortened to 20.
*/
`timescale 1ns/1ps
module tb_top;
  import cgr_pkg::*;
  localparam int LOCK = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errv, seq_busy, ce = 1, si;
  logic [11:0] paddr = 12'h000, out_div_code;
  logic [31:0] pwdata = 32'h0, prdata, rdv, ss_amount;
  logic [3:0] out_run, out_align, out_align_rise, ss_enable, ss_down, em, im;
  logic [3:0] align_seen = 4'h0; // Every output that got an align pulse.
  logic [63:0] freq_ofs_ppm;
  logic [51:0] phase_ofs;
  logic [7:0] ss_rate, c, d;
  logic [7:0] cfg [4], fst [4], pst [4], ini [4]; // Programmed values.
  logic [15:0] facc [4]; // Expected frequency offsets.
  logic [12:0] pacc [4]; // Expected phase offsets.
  int mismatches = 0, n_compared = 0, seed = 21, busy_n = 0, si_n = 0, b0, p;
  cgr_link_if u_cgr_link_if();
  cgr_dev #(.LOCK_CYC(LOCK)) u_cgr_dev (.pclk(pclk), .presetn(presetn), .ce(ce), .link(u_cgr_link_if.dev),
    .out_run(out_run), .out_align(out_align), .out_align_rise(out_align_rise), .synth_init(si),
    .out_div_code(out_div_code), .freq_ofs_ppm(freq_ofs_ppm), .phase_ofs(phase_ofs), .ss_amount(ss_amount),
    .ss_enable(ss_enable), .ss_down(ss_down), .ss_rate(ss_rate), .seq_busy(seq_busy));
  cgr_ctl u_cgr_ctl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_cgr_link_if.ctl));
  cgr_assertions #(.LOCK_CYC(LOCK)) u_cgr_assertions (.pclk(pclk), .presetn(presetn),
    .reg_addr(u_cgr_link_if.reg_addr), .reg_wdata(u_cgr_link_if.reg_wdata), .reg_wr(u_cgr_link_if.reg_wr),
    .reg_rd(u_cgr_link_if.reg_rd), .reg_rdata(u_cgr_link_if.reg_rdata), .reg_rvalid(u_cgr_link_if.reg_rvalid),
    .step_pins(u_cgr_link_if.step_pins), .out_run(out_run), .seq_busy(seq_busy));
  always #10 pclk = ~pclk;
  // Counts busy cycles and init pulses, and collects align pulses, which last one cycle only.
  always @(posedge pclk)
  begin
    if (seq_busy === 1'b1)
      busy_n <= busy_n + 1;
    if (si === 1'b1)
      si_n <= si_n + 1;
    align_seen <= align_seen | out_align;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; an idle cycle follows so strobes never change twice at one edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task poll;
    do apb(1'b0, APB_STAT, 32'h0); while (rdv[1:0] !== 2'b00);
  endtask : poll
  task dwr(input logic [7:0] a, input logic [7:0] dt);
    apb(1'b1, APB_XFER, {16'h0, dt, a});
    poll();
  endtask : dwr
  task drd(input logic [7:0] a, output logic [7:0] dt);
    apb(1'b1, APB_XFER, {15'h0, 1'b1, 8'h00, a});
    poll();
    dt = rdv[15:8];
  endtask : drd
  // Reads back every configuration byte; divider codes above the top one clamp.
  task rb;
    for (int n = 0; n < 4; n++)
    begin
      drd(OFS_CFG + 8'(n), d);
      check(d, {2'b0, cfg[n][5:3], (cfg[n][2:0] > DIV_MAX_CODE) ? DIV_MAX_CODE : cfg[n][2:0]});
      check(out_div_code[3*n +: 3], (cfg[n][2:0] > DIV_MAX_CODE) ? DIV_MAX_CODE : cfg[n][2:0]);
    end
  endtask : rb
  // Runs one soft reset and waits for the sequencer to go idle.
  task srst(input int len);
    b0 = busy_n;
    dwr(OFS_SRST, SRST_CMD);
    repeat (2) @(posedge pclk);
    if (len > 18)
      check(out_run, 4'b0100);
    while (seq_busy === 1'b1) @(posedge pclk);
    repeat (2) @(posedge pclk);
    check(busy_n - b0, len);
    check(out_run, 4'hF);
  endtask : srst
  // Applies a step command to the model: up and down together cancel.
  task upd(input logic [7:0] m, input logic fr);
    for (int n = 0; n < 4; n++)
    begin
      if (fr)
        facc[n] = facc[n] + (m[n] && !m[n+4] ? 16'(fst[n]) : 16'h0) - (m[n+4] && !m[n] ? 16'(fst[n]) : 16'h0);
      else
      begin
        p = $signed(pacc[n]) + (m[n] && !m[n+4] ? int'(pst[n]) : 0) - (m[n+4] && !m[n] ? int'(pst[n]) : 0);
        pacc[n] = 13'(p > 2250 ? 2250 : (p < -2250 ? -2250 : p));
      end
    end
  endtask : upd
  task acc;
    for (int n = 0; n < 4; n++)
    begin
      check(freq_ofs_ppm[16*n +: 16], facc[n]);
      check(phase_ofs[13*n +: 13], pacc[n]);
    end
  endtask : acc
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // The whole run needs under a thousand cycles; this bound only catches a hang.
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(out_run, 4'hF);
    check(ss_rate, SS_RATE_RST);
    apb(1'b0, 12'hFFC, 32'h0);
    check({errv, rdv[7:0]}, 9'h100);
    // Random configuration; output 2 always on, every divide code random.
    for (int n = 0; n < 4; n++)
    begin
      cfg[n] = 8'($random(seed)) & 8'h37;
      cfg[n][3] = (n == 2);
      ini[n] = 8'($random(seed));
      fst[n] = 8'($random(seed)) | 8'h01;
      pst[n] = (n == 1) ? 8'hFF : 8'($random(seed)) | 8'h01;
      facc[n] = 16'h0;
      pacc[n] = (cfg[n][2:0] == 3'h0) ? {{5{ini[n][7]}}, ini[n]} : 13'h0;
      em[n] = cfg[n][5] && cfg[n][2:0] == 3'h0;
      im[n] = cfg[n][4];
      dwr(OFS_CFG + 8'(n), cfg[n]);
      dwr(OFS_PINIT + 8'(n), ini[n]);
      dwr(OFS_FSTEP + 8'(n), fst[n]);
      dwr(OFS_PSTEP + 8'(n), pst[n]);
    end
    rb();
    dwr(OFS_SRST, 8'h03);
    check(seq_busy, 1'b0);
    srst(18 + LOCK);
    check(align_seen, em);
    check(out_align_rise, im);
    acc();
    drd(OFS_SRST, d);
    check(d, SRST_CMD);
    rb();
    dwr(OFS_MISC, 8'h01);
    srst(18);
    // Random serial steps, then repeated phase-up to reach the clamp.
    for (int i = 0; i < 16; i++)
    begin
      c = (i < 6) ? 8'($random(seed)) : 8'h0F;
      dwr(OFS_FCMD, c);
      dwr(OFS_PCMD, c);
      upd(c, 1'b1);
      upd(c, 1'b0);
      acc();
    end
    // Pin steps reach output 0 only; a second request while busy is refused.
    apb(1'b1, APB_PIN, 32'h5);
    apb(1'b1, APB_PIN, 32'hA);
    check(errv, 1'b1);
    poll();
    upd(8'h01, 1'b1);
    upd(8'h01, 1'b0);
    apb(1'b1, APB_PIN, 32'hA);
    poll();
    upd(8'h10, 1'b1);
    upd(8'h10, 1'b0);
    acc();
    dwr(OFS_SSMODE, 8'h03);
    dwr(OFS_SSAMT, 8'h3C);
    dwr(OFS_SSMODE + 8'h01, 8'h01);
    dwr(OFS_SSAMT + 8'h01, 8'h3C);
    check(ss_amount[15:0], {SS_CENTER_MAX, SS_DOWN_MAX});
    check({ss_enable, ss_down}, 8'h3D);
    dwr(OFS_SSRATE, 8'hC8);
    check(ss_rate, SS_RATE_MAX);
    dwr(OFS_SSRATE, 8'h0A);
    drd(OFS_SSRATE, d);
    check(d, SS_RATE_MIN);
    // With the clock enable low a register write must not land.
    ce <= 1'b0;
    apb(1'b1, APB_XFER, {16'h0, 8'h00, OFS_MISC});
    ce <= 1'b1;
    drd(OFS_MISC, d);
    check(d, 8'h01);
    check(si_n, 2);
    give_verdict();
  end
endmodule : tb_top
